// ---- dbguc_top.sv ----
// dbguc_top: apb register file, command handling, channel modes and flags of the debug uart
//
// Behaviour
// - receive ready flag requests receive dma transfer
// - transmit free flag requests transmit dma transfer
// - dma channel registers at 0x100 through 0x124
// - dma channel status shown in flags, interrupting
// - channel select: normal, echo, local, remote loopback
// - echo: receive pin copied to transmit pin
// - local loopback: transmitter feeds receiver, pin idle
// - remote loopback: pin to pin, engines disabled
// - debug channel flags in two top bits
// - debug channel flags can raise the interrupt
// - hard wired read only part identifier
// - extra identifier reads zero without extension
// - force bit holds test port reset asserted
// - force bit resets to zero
// - command bit 2 resets receiver at once
// - command bit 3 resets transmitter at once
// - bit 4 enables receiver unless bit 5
// - bit 5 disables receiver after current character
// - bit 6 enables transmitter unless bit 7
// - bit 7 disables transmitter after pending characters
// - bit 8 clears parity, framing, overrun flags
// - parity kind: even, odd, space, mark, none
`timescale 1ns/100ps
module dbguc_top (
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial pins
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	// dma channel handshake
	output logic             dma_rx_req,
	output logic             dma_tx_req,
	input  wire logic [3:0]  dma_chan_status,
	// debug channel and test port
	input  wire logic        dbg_chan_to_cpu_full,
	input  wire logic        dbg_chan_from_cpu_full,
	output logic             tap_reset_line_n,
	// interrupt
	output logic             irq
);
	dbguc_link_if lk ();

	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        pin_q;
	logic        tap_n_q;
	logic        irq_q;
	logic        dma_tx_req_q;
	logic        rx_en_q;
	logic        rx_off_pend_q;
	logic        tx_en_q;
	logic        tx_off_pend_q;
	logic [1:0]  ch_q;
	logic [2:0]  par_kind_q;
	logic [31:0] imr_q;
	logic        rx_ready_q;
	logic        ovr_q;
	logic        perr_q;
	logic        ferr_q;
	logic [7:0]  rhr_q;
	logic [7:0]  thr_q;
	logic        thr_full_q;
	logic [15:0] cd_q;
	logic [15:0] div_cnt_q;
	logic        tick_q;
	logic        fnr_q;
	logic [1:0]  dbg_q;
	logic [3:0]  dmast_q;
	logic [31:0] pdc_q [dbguc_pkg::PDC_WORDS];

	// apb phases: answer comes one cycle after the first access cycle
	wire        setup_acc = psel && penable && !pready_q;
	wire        xfer      = psel && penable && pready_q;
	wire        wr        = xfer && pwrite;
	wire        rd_done   = xfer && !pwrite;
	wire [11:0] a         = {paddr[11:2], 2'b00};
	wire [11:0] pdc_off   = a - dbguc_pkg::OFF_PDC_LO;
	wire [3:0]  pdc_idx   = pdc_off[5:2];

	wire hit_cmd  = (a == dbguc_pkg::OFF_CMD);
	wire hit_mode = (a == dbguc_pkg::OFF_MODE);
	wire hit_ier  = (a == dbguc_pkg::OFF_IER);
	wire hit_idr  = (a == dbguc_pkg::OFF_IDR);
	wire hit_imr  = (a == dbguc_pkg::OFF_IMR);
	wire hit_sr   = (a == dbguc_pkg::OFF_SR);
	wire hit_rhr  = (a == dbguc_pkg::OFF_RHR);
	wire hit_thr  = (a == dbguc_pkg::OFF_THR);
	wire hit_brg  = (a == dbguc_pkg::OFF_BRG);
	wire hit_cid  = (a == dbguc_pkg::OFF_CID);
	wire hit_exid = (a == dbguc_pkg::OFF_EXID);
	wire hit_fnr  = (a == dbguc_pkg::OFF_FNR);
	wire rsv_hit  = (a >= dbguc_pkg::OFF_RSV_LO) && (a <= dbguc_pkg::OFF_RSV_HI);
	wire pdc_hit  = (a >= dbguc_pkg::OFF_PDC_LO) && (a <= dbguc_pkg::OFF_PDC_HI);
	wire mapped   = hit_cmd || hit_mode || hit_ier || hit_idr || hit_imr || hit_sr || hit_rhr
		|| hit_thr || hit_brg || hit_cid || hit_exid || hit_fnr || rsv_hit || pdc_hit;

	// channel select decode
	wire is_echo   = (ch_q == dbguc_pkg::CH_ECHO);
	wire is_local  = (ch_q == dbguc_pkg::CH_LOCAL);
	wire is_remote = (ch_q == dbguc_pkg::CH_REMOTE);

	// commands
	wire cmd_wr  = wr && hit_cmd;
	wire rx_rst  = cmd_wr && pwdata[dbguc_pkg::CMD_RX_RESET];
	wire tx_rst  = cmd_wr && pwdata[dbguc_pkg::CMD_TX_RESET];
	wire rx_off  = cmd_wr && pwdata[dbguc_pkg::CMD_RX_OFF];
	wire tx_off  = cmd_wr && pwdata[dbguc_pkg::CMD_TX_OFF];
	wire rx_on   = cmd_wr && pwdata[dbguc_pkg::CMD_RX_ON] && !pwdata[dbguc_pkg::CMD_RX_OFF];
	wire tx_on   = cmd_wr && pwdata[dbguc_pkg::CMD_TX_ON] && !pwdata[dbguc_pkg::CMD_TX_OFF];
	wire clr_err = cmd_wr && pwdata[dbguc_pkg::CMD_CLR_ERR];
	wire thr_wr  = wr && hit_thr;
	wire rhr_rd  = rd_done && hit_rhr;

	// receiver enable; a disable while busy waits for the stop bit
	wire rx_active = lk.rx_busy && rx_en_q;
	wire rx_en_d   = rx_rst ? 1'b0 :
		rx_off ? (rx_active && rx_en_q) :
		rx_on ? 1'b1 :
		(rx_off_pend_q && !lk.rx_busy) ? 1'b0 : rx_en_q;
	wire rx_pend_d = (rx_rst || rx_on) ? 1'b0 : rx_off ? rx_active : (rx_off_pend_q && lk.rx_busy);

	// transmitter enable; a disable drains shifter and holding register first
	wire tx_work   = thr_full_q || lk.tx_busy;
	wire tx_en_d   = tx_rst ? 1'b0 :
		tx_off ? (tx_work && tx_en_q) :
		tx_on ? 1'b1 :
		(tx_off_pend_q && !tx_work) ? 1'b0 : tx_en_q;
	wire tx_pend_d = (tx_rst || tx_on) ? 1'b0 : tx_off ? (tx_work && tx_en_q) : (tx_off_pend_q && tx_work);
	wire tx_load   = tx_en_q && thr_full_q && !lk.tx_busy && !is_remote && !tx_rst;
	wire thr_full_d = tx_rst ? 1'b0 : thr_wr ? 1'b1 : tx_load ? 1'b0 : thr_full_q;

	// sticky flags; a new event wins over a clear in the same cycle
	wire rx_ready_d = lk.rx_done || (rx_ready_q && !rhr_rd);
	wire ovr_d      = (lk.rx_done && rx_ready_q && !rhr_rd) || (ovr_q && !clr_err);
	wire perr_d     = (lk.rx_done && lk.rx_par_err) || (perr_q && !clr_err);
	wire ferr_d     = (lk.rx_done && lk.rx_frm_err) || (ferr_q && !clr_err);
	wire tx_free    = tx_en_q && !thr_full_q;

	wire [31:0] sr_word = {dbg_q[1], dbg_q[0], 17'h0_0000,
		dmast_q[3], dmast_q[2], 1'b0, tx_free && !lk.tx_busy, 1'b0,
		perr_q, ferr_q, ovr_q, dmast_q[1], dmast_q[0], 1'b0, tx_free, rx_ready_q};
	wire [31:0] mode_word = {16'h0000, ch_q, 2'h0, par_kind_q, 9'h000};
	wire [31:0] exid_word = dbguc_pkg::ID_EXT ? dbguc_pkg::ID_EXTRA : 32'h0000_0000;
	wire [31:0] rd_word   = hit_mode ? mode_word :
		hit_imr  ? imr_q :
		hit_sr   ? sr_word :
		hit_rhr  ? {24'h00_0000, rhr_q} :
		hit_brg  ? {16'h0000, cd_q} :
		hit_cid  ? dbguc_pkg::CID_WORD :
		hit_exid ? exid_word :
		hit_fnr  ? {31'h0000_0000, fnr_q} :
		pdc_hit  ? pdc_q[pdc_idx] : 32'h0000_0000;

	// routing of pins and engine input per channel select
	wire pin_d = (is_echo || is_remote) ? serial_in_pin :
		is_local ? 1'b1 : lk.tx_out;
	wire [15:0] div_next = div_cnt_q + 16'h0001;

	assign lk.rx_in   = is_local ? lk.tx_out : serial_in_pin;
	assign lk.rx_run  = rx_en_q && !rx_off_pend_q && !is_remote;
	assign lk.rx_clr  = rx_rst;
	assign lk.tx_clr  = tx_rst;
	assign lk.tx_load = tx_load;
	assign lk.tx_data = thr_q;
	assign lk.parity  = par_kind_q;
	assign lk.tick16  = tick_q;

	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign serial_out_pin   = pin_q;
	assign tap_reset_line_n = tap_n_q;
	assign irq              = irq_q;
	assign dma_rx_req       = rx_ready_q;
	assign dma_tx_req       = dma_tx_req_q;

	dbguc_serial u_serial (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.lk      (lk.eng)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pready_q  <= setup_acc;
			prdata_q  <= (setup_acc && !pwrite) ? rd_word : 32'h0000_0000;
			pslverr_q <= setup_acc && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_en_q       <= 1'b0;
			rx_off_pend_q <= 1'b0;
			tx_en_q       <= 1'b0;
			tx_off_pend_q <= 1'b0;
			thr_full_q    <= 1'b0;
			dma_tx_req_q  <= 1'b0;
		end else if (ce) begin
			rx_en_q       <= rx_en_d;
			rx_off_pend_q <= rx_pend_d;
			tx_en_q       <= tx_en_d;
			tx_off_pend_q <= tx_pend_d;
			thr_full_q    <= thr_full_d;
			dma_tx_req_q  <= tx_en_d && !thr_full_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ready_q <= 1'b0;
			ovr_q      <= 1'b0;
			perr_q     <= 1'b0;
			ferr_q     <= 1'b0;
			rhr_q      <= dbguc_pkg::RHR_RST;
			thr_q      <= 8'h00;
		end else if (ce) begin
			rx_ready_q <= rx_ready_d;
			ovr_q      <= ovr_d;
			perr_q     <= perr_d;
			ferr_q     <= ferr_d;
			rhr_q      <= lk.rx_done ? lk.rx_data : rhr_q;
			thr_q      <= thr_wr ? pwdata[7:0] : thr_q;
		end
	end

	// software registers; reserved and read-only offsets take no write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch_q       <= dbguc_pkg::CH_RST;
			par_kind_q <= dbguc_pkg::PAR_RST;
			imr_q      <= dbguc_pkg::IMR_RST;
			cd_q       <= dbguc_pkg::BRG_RST;
			fnr_q      <= dbguc_pkg::FNR_RST;
		end else if (ce) begin
			if (wr && hit_mode) begin
				ch_q       <= pwdata[dbguc_pkg::MODE_CH_LSB +: 2];
				par_kind_q <= pwdata[dbguc_pkg::MODE_PAR_LSB +: 3];
			end
			if (wr && hit_ier) imr_q <= imr_q | (pwdata & dbguc_pkg::IRQ_VALID);
			if (wr && hit_idr) imr_q <= imr_q & ~pwdata;
			if (wr && hit_brg) cd_q <= pwdata[15:0];
			if (wr && hit_fnr) fnr_q <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < dbguc_pkg::PDC_WORDS; i++) pdc_q[i] <= 32'h0000_0000;
		end else if (ce && wr && pdc_hit) begin
			pdc_q[pdc_idx] <= pwdata;
		end
	end

	// divisor zero stops the sample tick and so both the transmitter and the receiver
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= 16'h0000;
			tick_q    <= 1'b0;
		end else if (ce) begin
			tick_q    <= (cd_q != 16'h0000) && (div_next == cd_q);
			div_cnt_q <= ((cd_q == 16'h0000) || (div_next == cd_q)) ? 16'h0000 : div_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q   <= 1'b1;
			tap_n_q <= 1'b1;
			irq_q   <= 1'b0;
			dbg_q   <= 2'h0;
			dmast_q <= 4'h0;
		end else if (ce) begin
			pin_q   <= pin_d;
			tap_n_q <= !fnr_q;
			irq_q   <= |(sr_word & imr_q);
			dbg_q   <= {dbg_chan_to_cpu_full, dbg_chan_from_cpu_full};
			dmast_q <= dma_chan_status;
		end
	end

	a_rx_dma_req: assert property (@(posedge pclk) disable iff (!presetn)
		ce && lk.rx_done |=> dma_rx_req) else $error("receive dma request missing");
	a_tx_dma_req: assert property (@(posedge pclk) disable iff (!presetn)
		ce && tx_en_q && !thr_full_q && !tx_off_pend_q && !cmd_wr && !thr_wr |=> dma_tx_req)
		else $error("transmit dma request missing");
	a_pdc_readback: assert property (@(posedge pclk) disable iff (!presetn)
		ce && setup_acc && !pwrite && pdc_hit |=> pready && prdata == $past(pdc_q[pdc_idx]))
		else $error("dma channel register read wrong");
	a_dma_status: assert property (@(posedge pclk) disable iff (!presetn)
		ce && dmast_q[0] && imr_q[dbguc_pkg::ST_END_RX] |=> irq) else $error("dma status not interrupting");
	a_echo_path: assert property (@(posedge pclk) disable iff (!presetn)
		ce && is_echo |=> serial_out_pin == $past(serial_in_pin)) else $error("echo path broken");
	a_local_idle: assert property (@(posedge pclk) disable iff (!presetn)
		ce && is_local |=> serial_out_pin) else $error("local loopback pin not idle");
	a_remote_path: assert property (@(posedge pclk) disable iff (!presetn)
		ce && is_remote |-> !lk.tx_load && !lk.rx_run ##1 serial_out_pin == $past(serial_in_pin))
		else $error("remote loopback not isolated");
	a_dbg_irq: assert property (@(posedge pclk) disable iff (!presetn)
		ce && dbg_q[1] && imr_q[dbguc_pkg::ST_DBG_TO_CPU] |=> irq) else $error("debug flag not interrupting");
	a_tap_force: assert property (@(posedge pclk) disable iff (!presetn)
		ce && fnr_q |=> !tap_reset_line_n) else $error("test port reset not held");
	a_rx_reset: assert property (@(posedge pclk) disable iff (!presetn)
		ce && rx_rst |=> !rx_en_q && !lk.rx_busy) else $error("receiver reset incomplete");
	a_tx_reset: assert property (@(posedge pclk) disable iff (!presetn)
		ce && tx_rst |=> !tx_en_q && !lk.tx_busy && !dma_tx_req) else $error("transmitter reset incomplete");
	a_rx_enable: assert property (@(posedge pclk) disable iff (!presetn)
		ce && rx_on && !rx_rst |=> rx_en_q) else $error("receiver enable ignored");
	a_rx_drain: assert property (@(posedge pclk) disable iff (!presetn)
		ce && rx_off && !rx_rst && rx_active |=> rx_en_q && rx_off_pend_q) else $error("receiver stopped mid character");
	a_tx_enable: assert property (@(posedge pclk) disable iff (!presetn)
		ce && tx_on && !tx_rst |=> tx_en_q) else $error("transmitter enable ignored");
	a_tx_drain: assert property (@(posedge pclk) disable iff (!presetn)
		ce && tx_off && !tx_rst && thr_full_q && tx_en_q |=> tx_en_q) else $error("transmitter stopped early");
	a_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
		ce && clr_err && !lk.rx_done |=> !ovr_q && !perr_q && !ferr_q) else $error("error flags not cleared");
	a_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
		ce && setup_acc && !pwrite && rsv_hit |=> pready && prdata == 32'h0000_0000 && !pslverr)
		else $error("reserved read not zero");

endmodule : dbguc_top

// ---- dbguc_pkg.sv ----
// dbguc_pkg: register map, field positions, reset values and identity of the debug uart
package dbguc_pkg;

	// register byte offsets
	localparam logic [11:0] OFF_CMD    = 12'h000;
	localparam logic [11:0] OFF_MODE   = 12'h004;
	localparam logic [11:0] OFF_IER    = 12'h008;
	localparam logic [11:0] OFF_IDR    = 12'h00c;
	localparam logic [11:0] OFF_IMR    = 12'h010;
	localparam logic [11:0] OFF_SR     = 12'h014;
	localparam logic [11:0] OFF_RHR    = 12'h018;
	localparam logic [11:0] OFF_THR    = 12'h01c;
	localparam logic [11:0] OFF_BRG    = 12'h020;
	localparam logic [11:0] OFF_RSV_LO = 12'h024;
	localparam logic [11:0] OFF_RSV_HI = 12'h03c;
	localparam logic [11:0] OFF_CID    = 12'h040;
	localparam logic [11:0] OFF_EXID   = 12'h044;
	localparam logic [11:0] OFF_FNR    = 12'h048;
	localparam logic [11:0] OFF_PDC_LO = 12'h100;
	localparam logic [11:0] OFF_PDC_HI = 12'h124;
	localparam int          PDC_WORDS  = 10;

	// command_bits positions
	localparam int CMD_RX_RESET  = 2;
	localparam int CMD_TX_RESET  = 3;
	localparam int CMD_RX_ON     = 4;
	localparam int CMD_RX_OFF    = 5;
	localparam int CMD_TX_ON     = 6;
	localparam int CMD_TX_OFF    = 7;
	localparam int CMD_CLR_ERR   = 8;

	// line_mode field positions and channel_select codes
	localparam int         MODE_PAR_LSB = 9;
	localparam int         MODE_CH_LSB  = 14;
	localparam logic [1:0] CH_NORMAL    = 2'h0;
	localparam logic [1:0] CH_ECHO      = 2'h1;
	localparam logic [1:0] CH_LOCAL     = 2'h2;
	localparam logic [1:0] CH_REMOTE    = 2'h3;

	// line_flags positions
	localparam int ST_RX_CHAR_READY   = 0;
	localparam int ST_TX_HOLDING_FREE = 1;
	localparam int ST_END_RX          = 3;
	localparam int ST_END_TX          = 4;
	localparam int ST_OVERRUN         = 5;
	localparam int ST_FRAMING         = 6;
	localparam int ST_PARITY_ERR      = 7;
	localparam int ST_TX_EMPTY        = 9;
	localparam int ST_TX_BUF_EMPTY    = 11;
	localparam int ST_RX_BUF_FULL     = 12;
	localparam int ST_DBG_FROM_CPU    = 30;
	localparam int ST_DBG_TO_CPU      = 31;
	localparam logic [31:0] IRQ_VALID = 32'hc000_1afb;

	// reset values
	localparam logic [31:0] IMR_RST = 32'h0000_0000;
	localparam logic [1:0]  CH_RST  = 2'h0;
	localparam logic [2:0]  PAR_RST = 3'h0;
	localparam logic [7:0]  RHR_RST = 8'h00;
	localparam logic [15:0] BRG_RST = 16'h0000;
	localparam logic        FNR_RST = 1'b0;

	// receiver timing in sample ticks (16 per bit)
	localparam logic [3:0] START_LOW_LAST = 4'h7;
	localparam logic [3:0] BIT_LAST_TICK  = 4'hf;

	// identity values below are arbitrary
	localparam logic        ID_EXT      = 1'b0;
	localparam logic [2:0]  ID_NVM_KIND = 3'h1;
	localparam logic [7:0]  ID_PERIPH   = 8'h5a;
	localparam logic [3:0]  ID_SRAM     = 4'h3;
	localparam logic [3:0]  ID_NVM_SIZE = 4'h2;
	localparam logic [2:0]  ID_CPU      = 3'h4;
	localparam logic [4:0]  ID_VERSION  = 5'h01;
	localparam logic [31:0] ID_EXTRA    = 32'h0000_0a5a;
	// ext 31, nvm kind 30:28, peripherals 27:20, ram 19:16, nvm size 11:8, cpu 7:5, revision 4:0
	localparam logic [31:0] CID_WORD = {ID_EXT, ID_NVM_KIND, ID_PERIPH, ID_SRAM, 4'h0,
		ID_NVM_SIZE, ID_CPU, ID_VERSION};

	// parity bit for a character; top bit of kind means none
	function automatic logic dbguc_parity(input logic [7:0] d, input logic [2:0] k);
		case (k[1:0])
			2'h0: return ^d;
			2'h1: return ~^d;
			2'h2: return 1'b0;
			default: return 1'b1;
		endcase
	endfunction : dbguc_parity

endpackage : dbguc_pkg

// ---- dbguc_link_if.sv ----
// dbguc_link_if: signals between the control logic and the serial engine
`timescale 1ns/100ps
interface dbguc_link_if;
	logic       tick16;
	logic       rx_in;
	logic       tx_out;
	logic       rx_run;
	logic       rx_clr;
	logic       tx_clr;
	logic [2:0] parity;
	logic       tx_load;
	logic [7:0] tx_data;
	logic       tx_busy;
	logic       rx_busy;
	logic       rx_done;
	logic [7:0] rx_data;
	logic       rx_par_err;
	logic       rx_frm_err;
	modport ctrl (output tick16, rx_in, rx_run, rx_clr, tx_clr, parity, tx_load, tx_data,
		input tx_out, tx_busy, rx_busy, rx_done, rx_data, rx_par_err, rx_frm_err);
	modport eng (input tick16, rx_in, rx_run, rx_clr, tx_clr, parity, tx_load, tx_data,
		output tx_out, tx_busy, rx_busy, rx_done, rx_data, rx_par_err, rx_frm_err);
endinterface : dbguc_link_if

// ---- dbguc_serial.sv ----
// dbguc_serial: character shifter and receiver sampler on the 16x sample tick
`timescale 1ns/100ps
module dbguc_serial (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// control side
	dbguc_link_if.eng lk
);
	logic [10:0] tx_sh_q;
	logic [3:0]  tx_ph_q;
	logic [3:0]  tx_left_q;
	logic [9:0]  rx_sh_q;
	logic [3:0]  rx_ph_q;
	logic [3:0]  rx_left_q;
	logic        rx_busy_q;
	logic        rx_done_q;
	logic [7:0]  rx_data_q;
	logic        rx_perr_q;
	logic        rx_ferr_q;

	wire       no_par   = lk.parity[2];
	wire [9:0] rx_final = {lk.rx_in, rx_sh_q[9:1]};
	wire [7:0] rx_byte  = no_par ? rx_final[8:1] : rx_final[7:0];
	wire       tx_step  = lk.tick16 && (tx_left_q != 4'h0);
	wire       tx_par   = no_par ? 1'b1 : dbguc_pkg::dbguc_parity(lk.tx_data, lk.parity);

	assign lk.tx_out     = tx_sh_q[0];
	assign lk.tx_busy    = (tx_left_q != 4'h0);
	assign lk.rx_busy    = rx_busy_q;
	assign lk.rx_done    = rx_done_q;
	assign lk.rx_data    = rx_data_q;
	assign lk.rx_par_err = rx_perr_q;
	assign lk.rx_frm_err = rx_ferr_q;

	// start, eight data, optional parity, stop; spare top bit keeps line high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_sh_q   <= 11'h7ff;
			tx_ph_q   <= 4'h0;
			tx_left_q <= 4'h0;
		end else if (ce) begin
			if (lk.tx_clr) begin
				tx_sh_q   <= 11'h7ff;
				tx_ph_q   <= 4'h0;
				tx_left_q <= 4'h0;
			end else if (lk.tx_load) begin
				tx_sh_q   <= {1'b1, tx_par, lk.tx_data, 1'b0};
				tx_ph_q   <= 4'h0;
				tx_left_q <= no_par ? 4'ha : 4'hb;
			end else if (tx_step) begin
				tx_ph_q <= tx_ph_q + 4'h1;
				if (tx_ph_q == dbguc_pkg::BIT_LAST_TICK) begin
					tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
					tx_left_q <= tx_left_q - 4'h1;
				end
			end
		end
	end

	// a started character runs to its stop bit even if rx_run falls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sh_q   <= 10'h000;
			rx_ph_q   <= 4'h0;
			rx_left_q <= 4'h0;
			rx_busy_q <= 1'b0;
			rx_done_q <= 1'b0;
			rx_data_q <= 8'h00;
			rx_perr_q <= 1'b0;
			rx_ferr_q <= 1'b0;
		end else if (ce) begin
			rx_done_q <= 1'b0;
			if (lk.rx_clr) begin
				rx_ph_q   <= 4'h0;
				rx_busy_q <= 1'b0;
			end else if (!rx_busy_q) begin
				if (!lk.rx_run || (lk.tick16 && lk.rx_in)) begin
					rx_ph_q <= 4'h0;
				end else if (lk.tick16 && rx_ph_q == dbguc_pkg::START_LOW_LAST) begin
					rx_ph_q   <= 4'h0;
					rx_busy_q <= 1'b1;
					rx_left_q <= no_par ? 4'h9 : 4'ha;
				end else if (lk.tick16) begin
					rx_ph_q <= rx_ph_q + 4'h1;
				end
			end else if (lk.tick16) begin
				rx_ph_q <= rx_ph_q + 4'h1;
				if (rx_ph_q == dbguc_pkg::BIT_LAST_TICK) begin
					rx_sh_q   <= rx_final;
					rx_left_q <= rx_left_q - 4'h1;
					if (rx_left_q == 4'h1) begin
						rx_busy_q <= 1'b0;
						rx_done_q <= 1'b1;
						rx_data_q <= rx_byte;
						rx_perr_q <= !no_par && (rx_final[8] != dbguc_pkg::dbguc_parity(rx_byte, lk.parity));
						rx_ferr_q <= !rx_final[9];
					end
				end
			end
		end
	end

endmodule : dbguc_serial

// ---- dbguc_term.sv ----
// dbguc_term: serial terminal model driving the receive pin
`timescale 1ns/100ps
module dbguc_term (
	// clock
	input wire logic pclk,
	// serial line, idle high
	output logic     line
);
	initial line = 1'b1;
	task automatic hold(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge pclk);
	endtask : hold
	// start, data lsb first, stop; line back at idle level after
	task automatic send(input logic [7:0] c, input int bt);
		hold(1'b0, bt);
		for (int i = 0; i < 8; i++) hold(c[i], bt);
		hold(1'b1, bt);
	endtask : send
endmodule : dbguc_term

// ---- dbguc_top_tb.sv ----
// dbguc_top_tb: register, mode and flag scenarios for the debug uart
`timescale 1ns/100ps
module dbguc_top_tb;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, last_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        sin, sout, rx_req, tx_req, to_cpu, from_cpu, tap_n, irq;
	logic [3:0]  dma_st;
	int          n_mismatch, n_compared, cyc;
	dbguc_term i_dbguc_term (.pclk(pclk), .line(sin));
	dbguc_top i_dbguc_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_in_pin(sin), .serial_out_pin(sout), .dma_rx_req(rx_req),
		.dma_tx_req(tx_req), .dma_chan_status(dma_st), .dbg_chan_to_cpu_full(to_cpu),
		.dbg_chan_from_cpu_full(from_cpu), .tap_reset_line_n(tap_n), .irq(irq));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic report_and_stop;
		if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk1
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next setup never re-drives psel in this time step
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r & m, e);
	endtask : rd
	task automatic t_regs;
		rd(dbguc_pkg::OFF_MODE, 32'hffff_ffff, 32'h0);
		rd(dbguc_pkg::OFF_RHR, 32'hffff_ffff, 32'h0);
		rd(dbguc_pkg::OFF_FNR, 32'hffff_ffff, 32'h0);
		chk1(tap_n, 1'b1);
		rd(dbguc_pkg::OFF_CID, 32'hffff_ffff, dbguc_pkg::CID_WORD);
		rd(dbguc_pkg::OFF_EXID, 32'hffff_ffff, 32'h0);
		wr(dbguc_pkg::OFF_RSV_LO, 32'hffff_ffff);
		rd(dbguc_pkg::OFF_RSV_LO, 32'hffff_ffff, 32'h0);
		wr(dbguc_pkg::OFF_PDC_HI, 32'h1234_5678);
		rd(dbguc_pkg::OFF_PDC_HI, 32'hffff_ffff, 32'h1234_5678);
		rd(12'h04c, 32'hffff_ffff, 32'h0);
		chk1(last_err, 1'b1);
		wr(dbguc_pkg::OFF_FNR, 32'h1);
		repeat (2) @(posedge pclk);
		chk1(tap_n, 1'b0);
	endtask : t_regs
	task automatic t_flags;
		to_cpu <= 1'b1;
		from_cpu <= 1'b1;
		dma_st <= 4'hf;
		wr(dbguc_pkg::OFF_CMD, 32'h100);
		rd(dbguc_pkg::OFF_SR, 32'hc000_18f8, 32'hc000_1818);
		wr(dbguc_pkg::OFF_IER, 32'h8000_0000);
		repeat (3) @(posedge pclk);
		chk1(irq, 1'b1);
		wr(dbguc_pkg::OFF_IDR, 32'h8000_0000);
		repeat (3) @(posedge pclk);
		chk1(irq, 1'b0);
	endtask : t_flags
	task automatic t_tx;
		wr(dbguc_pkg::OFF_CMD, 32'h40);
		repeat (2) @(posedge pclk);
		chk1(tx_req, 1'b1);
		wr(dbguc_pkg::OFF_CMD, 32'hc0);
		repeat (2) @(posedge pclk);
		chk1(tx_req, 1'b0);
	endtask : t_tx
	task automatic t_modes;
		logic [31:0] m[3] = '{32'hc800, 32'h4800, 32'h8800};
		logic        lo[3] = '{1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 3; i++) begin
			wr(dbguc_pkg::OFF_MODE, m[i]);
			i_dbguc_term.hold(1'b0, 4);
			chk1(sout, lo[i]);
			i_dbguc_term.hold(1'b1, 4);
			chk1(sout, 1'b1);
		end
	endtask : t_modes
	task automatic t_rx;
		wr(dbguc_pkg::OFF_MODE, 32'h800);
		wr(dbguc_pkg::OFF_BRG, 32'h1);
		wr(dbguc_pkg::OFF_CMD, 32'h10);
		i_dbguc_term.send(8'ha5, 16);
		while (rx_req !== 1'b1) @(posedge pclk);
		chk1(rx_req, 1'b1);
		rd(dbguc_pkg::OFF_RHR, 32'hff, 32'ha5);
		repeat (2) @(posedge pclk);
		chk1(rx_req, 1'b0);
	endtask : t_rx
	initial begin
		{ce, psel, penable, pwrite, to_cpu, from_cpu, presetn} = 7'h40;
		{paddr, pwdata, dma_st} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_flags();
		t_tx();
		t_modes();
		t_rx();
		report_and_stop();
	end
endmodule : dbguc_top_tb
